// ===== verilog/paecr_pkg.sv
// Constants for the auto-negotiation expansion and vendor configuration registers
`default_nettype none
package paecr_pkg;
	// AXI4-Lite geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Register indices; byte address is four times the index
	localparam logic [5:0] AN_EXP_IDX = 6'h06;
	localparam logic [5:0] VEND_CFG_IDX = 6'h10;
	// Expansion register fields
	localparam int AE_PDF_BIT = 4;
	localparam int AE_LPNP_BIT = 3;
	localparam int AE_LNP_BIT = 2;
	localparam int AE_PAGE_BIT = 1;
	localparam int AE_LPAN_BIT = 0;
	localparam int AE_RSV_LSB = 5;
	// Vendor configuration fields
	localparam int VC_BP_CODE_BIT = 15;
	localparam int VC_BYPASS_SCRAMBLING_BIT = 14;
	localparam int VC_BYPASS_SYMBOL_ALIGNMENT_BIT = 13;
	localparam int VC_FORCE_SD_BIT = 12;
	localparam int VC_RSV11_BIT = 11;
	localparam int VC_TX100_BIT = 10;
	localparam int VC_RSV9_BIT = 9;
	localparam int VC_RSV8_BIT = 8;
	localparam int VC_FLINK_BIT = 7;
	localparam int VC_RSV6_BIT = 6;
	localparam int VC_RSV5_BIT = 5;
	localparam int VC_APR_BIT = 4;
	localparam int VC_PHY_STATE_MACHINE_RESET_BIT = 3;
	localparam int VC_PRE_BIT = 2;
	localparam int VC_SLEEP_BIT = 1;
	localparam int VC_LOOP_BIT = 0;
	// Reset value: 100BASE-TX, auto power reduce and preamble suppression on
	localparam logic [15:0] VC_RESET = 16'h0414;
	// Bits stored by the config flop; bit 9 is read-only, bit 3 lives apart
	localparam logic [15:0] VC_WR_MASK = 16'hFDF7;
	// State-machine reset pulse length
	localparam int CLK_PERIOD_NS = 10;
	localparam int PHY_STATE_MACHINE_RESET_TIME_NS = 160;
	localparam int PHY_STATE_MACHINE_RESET_CYCLES = (PHY_STATE_MACHINE_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SMCNT_W = 5;
endpackage
`default_nettype wire

// ===== verilog/paecr_regs.sv
// Expansion status and vendor configuration registers behind an AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module paecr_regs
	import paecr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [DATA_W/8-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic parallelDetectFault,
	input wire logic partnerNextPageCapable,
	input wire logic partnerAutonegCapable,
	input wire logic pageReceived,
	output logic bypassBlockCoding,
	output logic bypassScrambling,
	output logic bypassSymbolAlignment,
	output logic forceSignalDetect,
	output logic tx100Mode,
	output logic forceLink100,
	output logic autoPowerReduceEnable,
	output logic phyStateMachineReset,
	output logic mgmtPreambleSuppress,
	output logic sleepMode,
	output logic remoteLoopOut
);

	function automatic logic isReg(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
		isReg = (addr == {idx, 2'b00});
	endfunction

	logic awReadyFf;
	logic awHeldFf;
	logic [ADDR_W-1:0] awAddrFf;
	logic wReadyFf;
	logic wHeldFf;
	logic [15:0] wDataFf;
	logic [1:0] wStrbFf;
	logic bValidFf;
	logic [1:0] bRespFf;
	logic arReadyFf;
	logic rValidFf;
	logic [DATA_W-1:0] rDataFf;
	logic [1:0] rRespFf;
	logic pdfFf;
	logic pageRxFf;
	logic [15:0] cfgFf;
	logic [15:0] nxt_cfgFf;
	logic [15:0] wrMask;
	logic smRstFf;
	logic [SMCNT_W-1:0] smCntFf;
	logic wrDo;
	logic wrCfg;
	logic rdFire;
	logic rdExp;
	logic smStart;
	logic smDone;
	logic [15:0] expView;
	logic [15:0] cfgView;

	////////////////////////////////////////////////////////////////////////////
	// Write channel: address and data taken in either order
	assign wrDo = awHeldFf && wHeldFf && !bValidFf;
	assign wrCfg = wrDo && isReg(awAddrFf, VEND_CFG_IDX);

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			awReadyFf <= 1'b0;
			awHeldFf <= 1'b0;
			awAddrFf <= '0;
		end
		else if (s_axi_awvalid && awReadyFf)
		begin
			awReadyFf <= 1'b0;
			awHeldFf <= 1'b1;
			awAddrFf <= s_axi_awaddr;
		end
		else if (wrDo)
			awHeldFf <= 1'b0;
		else if (!awHeldFf && !bValidFf)
			awReadyFf <= 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wReadyFf <= 1'b0;
			wHeldFf <= 1'b0;
			wDataFf <= 16'h0000;
			wStrbFf <= 2'h0;
		end
		else if (s_axi_wvalid && wReadyFf)
		begin
			wReadyFf <= 1'b0;
			wHeldFf <= 1'b1;
			wDataFf <= s_axi_wdata[15:0];
			wStrbFf <= s_axi_wstrb[1:0];
		end
		else if (wrDo)
			wHeldFf <= 1'b0;
		else if (!wHeldFf && !bValidFf)
			wReadyFf <= 1'b1;
	end

	// Writes to the read-only expansion register are accepted and dropped
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			bValidFf <= 1'b0;
			bRespFf <= RESP_OKAY;
		end
		else if (wrDo)
		begin
			bValidFf <= 1'b1;
			bRespFf <= (isReg(awAddrFf, VEND_CFG_IDX) || isReg(awAddrFf, AN_EXP_IDX))
				? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			bValidFf <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read channel
	assign rdFire = s_axi_arvalid && arReadyFf;
	assign rdExp = rdFire && isReg(s_axi_araddr, AN_EXP_IDX);

	always_comb
	begin
		expView = 16'h0000;
		expView[AE_PDF_BIT] = pdfFf;
		expView[AE_LPNP_BIT] = partnerNextPageCapable;
		expView[AE_LNP_BIT] = 1'b0;
		expView[AE_PAGE_BIT] = pageRxFf;
		expView[AE_LPAN_BIT] = partnerAutonegCapable;
		cfgView = cfgFf;
		cfgView[VC_PHY_STATE_MACHINE_RESET_BIT] = smRstFf;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			arReadyFf <= 1'b0;
			rValidFf <= 1'b0;
			rDataFf <= 32'h0000_0000;
			rRespFf <= RESP_OKAY;
		end
		else if (rdFire)
		begin
			arReadyFf <= 1'b0;
			rValidFf <= 1'b1;
			rRespFf <= RESP_OKAY;
			if (isReg(s_axi_araddr, AN_EXP_IDX))
				rDataFf <= {16'h0000, expView};
			else if (isReg(s_axi_araddr, VEND_CFG_IDX))
				rDataFf <= {16'h0000, cfgView};
			else
			begin
				rDataFf <= 32'h0000_0000;
				rRespFf <= RESP_SLVERR;
			end
		end
		else if (rValidFf && s_axi_rready)
			rValidFf <= 1'b0;
		else if (!rValidFf)
			arReadyFf <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Latched status; a new event in the clearing read cycle wins
	always_ff @(posedge mclk)
	begin
		if (rst)
			pdfFf <= 1'b0;
		else
			pdfFf <= parallelDetectFault || (pdfFf && !rdExp);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			pageRxFf <= 1'b0;
		else
			pageRxFf <= pageReceived || (pageRxFf && !rdExp);
	end

	////////////////////////////////////////////////////////////////////////////
	// Vendor configuration; reserved writable bits are stored as written
	always_comb
	begin
		wrMask = {{8{wStrbFf[1]}}, {8{wStrbFf[0]}}} & VC_WR_MASK;
		nxt_cfgFf = (cfgFf & ~wrMask) | (wDataFf & wrMask);
	end

	// Sleep keeps every other bit, so waking restores the old setup
	always_ff @(posedge mclk)
	begin
		if (rst)
			cfgFf <= VC_RESET;
		else if (wrCfg)
			cfgFf <= nxt_cfgFf;
	end

	assign smStart = wrCfg && ((wStrbFf[0] && wDataFf[VC_PHY_STATE_MACHINE_RESET_BIT])
		|| (cfgFf[VC_SLEEP_BIT] && !nxt_cfgFf[VC_SLEEP_BIT]));
	assign smDone = smRstFf && (smCntFf == SMCNT_W'(PHY_STATE_MACHINE_RESET_CYCLES - 1));

	// Restart while a reset runs extends it to a full length
	always_ff @(posedge mclk)
	begin
		if (rst)
			smRstFf <= 1'b0;
		else if (smStart)
			smRstFf <= 1'b1;
		else if (smDone)
			smRstFf <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (rst || smStart || !smRstFf)
			smCntFf <= '0;
		else
			smCntFf <= smCntFf + SMCNT_W'(1);
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flops
	assign s_axi_awready = awReadyFf;
	assign s_axi_wready = wReadyFf;
	assign s_axi_bvalid = bValidFf;
	assign s_axi_bresp = bRespFf;
	assign s_axi_arready = arReadyFf;
	assign s_axi_rvalid = rValidFf;
	assign s_axi_rdata = rDataFf;
	assign s_axi_rresp = rRespFf;
	assign bypassBlockCoding = cfgFf[VC_BP_CODE_BIT];
	assign bypassScrambling = cfgFf[VC_BYPASS_SCRAMBLING_BIT];
	assign bypassSymbolAlignment = cfgFf[VC_BYPASS_SYMBOL_ALIGNMENT_BIT];
	assign forceSignalDetect = cfgFf[VC_FORCE_SD_BIT];
	assign tx100Mode = cfgFf[VC_TX100_BIT];
	assign forceLink100 = cfgFf[VC_FLINK_BIT];
	assign autoPowerReduceEnable = cfgFf[VC_APR_BIT];
	assign phyStateMachineReset = smRstFf;
	assign mgmtPreambleSuppress = cfgFf[VC_PRE_BIT];
	assign sleepMode = cfgFf[VC_SLEEP_BIT];
	assign remoteLoopOut = cfgFf[VC_LOOP_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Checks
	localparam int SM_MAX = 17;
	logic rdWasExp;

	always_ff @(posedge mclk)
	begin
		if (rst)
			rdWasExp <= 1'b0;
		else if (rdFire)
			rdWasExp <= isReg(s_axi_araddr, AN_EXP_IDX);
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	property p_expZero;
		rValidFf && rdWasExp |-> rDataFf[31:AE_RSV_LSB] == '0 && !rDataFf[AE_LNP_BIT];
	endproperty
	a_expZero: assert property (p_expZero) else $error("expansion reserved bits nonzero");

	property p_pdfSet;
		parallelDetectFault |=> pdfFf;
	endproperty
	a_pdfSet: assert property (p_pdfSet) else $error("fault not latched");

	property p_pdfHold;
		pdfFf && !rdExp |=> pdfFf;
	endproperty
	a_pdfHold: assert property (p_pdfHold) else $error("fault dropped before read");

	property p_partner;
		rdExp |=> rDataFf[AE_LPNP_BIT] == $past(partnerNextPageCapable)
			&& rDataFf[AE_LPAN_BIT] == $past(partnerAutonegCapable);
	endproperty
	a_partner: assert property (p_partner) else $error("partner bits wrong");

	property p_pageClr;
		rdExp && !pageReceived |=> !pageRxFf;
	endproperty
	a_pageClr: assert property (p_pageClr) else $error("page bit not cleared on read");

	property p_resetVals;
		$fell(rst) |-> tx100Mode && autoPowerReduceEnable && mgmtPreambleSuppress && !sleepMode;
	endproperty
	a_resetVals: assert property (p_resetVals) else $error("config reset value wrong");

	property p_smSelfClr;
		$rose(phyStateMachineReset) |-> ##[1:SM_MAX] !phyStateMachineReset;
	endproperty
	a_smSelfClr: assert property (p_smSelfClr) else $error("state reset did not clear");

	property p_wake;
		$fell(sleepMode) |-> phyStateMachineReset;
	endproperty
	a_wake: assert property (p_wake) else $error("no reset on wake");

	property p_loopWr;
		wrCfg && wStrbFf[0] |=> remoteLoopOut == $past(wDataFf[VC_LOOP_BIT]);
	endproperty
	a_loopWr: assert property (p_loopWr) else $error("loop bit not written");

endmodule // paecr_regs
`default_nettype wire

// ===== testbench/paecr_mgmt_model.sv
// Management controller model: AXI4-Lite master, one transfer at a time
`timescale 1ns/1ns
`default_nettype none
module paecr_mgmt_model
	import paecr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic go,
	input wire logic isWrite,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] data,
	input wire logic [3:0] strb,
	output logic done,
	output logic [DATA_W-1:0] rdOut,
	output logic [1:0] respOut,
	output logic [ADDR_W-1:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [DATA_W-1:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [ADDR_W-1:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	logic busy_ff;
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			{awvalid, wvalid, bready, arvalid, rready, busy_ff, done} <= 7'h00;
			{awaddr, araddr, wdata, wstrb, rdOut, respOut} <= '0;
		end
		else
		begin
			done <= 1'b0;
			if (go && !busy_ff)
			begin
				awaddr <= addr;
				araddr <= addr;
				// Reserved writable bits always go out as zero
				wdata <= data & ~32'h0000_0960;
				wstrb <= strb;
				{awvalid, wvalid, bready} <= {3{isWrite}};
				{arvalid, rready} <= {2{!isWrite}};
				busy_ff <= 1'b1;
			end
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (bvalid && bready)
			begin
				{bready, busy_ff, done} <= 3'b001;
				respOut <= bresp;
			end
			if (rvalid && rready)
			begin
				{rready, busy_ff, done} <= 3'b001;
				respOut <= rresp;
				rdOut <= rdata;
			end
		end
	end
endmodule // paecr_mgmt_model
`default_nettype wire

// ===== testbench/phy_autoneg_expansion_and_config_regs_bench.sv
// Bench for the expansion status and vendor configuration registers
`timescale 1ns/1ns
`default_nettype none
module phy_autoneg_expansion_and_config_regs_bench;
	import paecr_pkg::*;
	logic mclk = 0, rst = 1, go = 0, isWrite = 0, parallel_detect_fault = 0, lpNp = 0, lpAn = 0, pageRx = 0;
	logic [7:0] addr = 0, aw, ar;
	logic [31:0] data = 0, wd, rd, rdOut;
	logic [3:0] strb = 0, ws;
	logic [1:0] br, rr, respOut;
	logic awv, awr, wv, wr, bv, brd, arv, arr, rv, rrd, done;
	logic bbc, bsc, bsa, fsd, tx, fl, apr, smr, pre, slp, lp;
	int fail_count = 0, n_compared = 0, cycles = 0, smLen = 0, smRun = 0;
	paecr_regs dut (.mclk(mclk), .rst(rst), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .parallelDetectFault(parallel_detect_fault),
		.partnerNextPageCapable(lpNp), .partnerAutonegCapable(lpAn), .pageReceived(pageRx),
		.bypassBlockCoding(bbc), .bypassScrambling(bsc), .bypassSymbolAlignment(bsa), .forceSignalDetect(fsd),
		.tx100Mode(tx), .forceLink100(fl), .autoPowerReduceEnable(apr), .phyStateMachineReset(smr),
		.mgmtPreambleSuppress(pre), .sleepMode(slp), .remoteLoopOut(lp));
	paecr_mgmt_model mgmt (.mclk(mclk), .rst(rst), .go(go), .isWrite(isWrite), .addr(addr), .data(data),
		.strb(strb), .done(done), .rdOut(rdOut), .respOut(respOut), .awaddr(aw), .awvalid(awv),
		.awready(awr), .wdata(wd), .wstrb(ws), .wvalid(wv), .wready(wr), .bresp(br), .bvalid(bv),
		.bready(brd), .araddr(ar), .arvalid(arv), .arready(arr), .rdata(rd), .rresp(rr), .rvalid(rv),
		.rready(rrd));
	always #5 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////////////
	// Pulse length of the state reset and the hang guard
	always @(posedge mclk)
	begin
		cycles++;
		if (smr === 1'b1)
			smRun++;
		else if (smRun != 0)
		begin
			smLen = smRun;
			smRun = 0;
		end
		if (cycles == 4000)
		begin
			fail_count++;
			$display("BAD %0t timeout", $time);
			test_done();
		end
	end
	function automatic logic [15:0] outs();
		return {bbc, bsc, bsa, fsd, 1'b0, tx, 2'b00, fl, 2'b00, apr, smr, pre, slp, lp};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One bus transfer; done is sampled at the edge, before that edge's updates
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge mclk);
		go <= 1'b1;
		isWrite <= w;
		addr <= a;
		data <= d;
		strb <= s;
		@(posedge mclk);
		go <= 1'b0;
		while (done !== 1'b1)
			@(posedge mclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		acc(0, 8'h40, 0, 0);
		check(rdOut, 32'h0000_0414);
		check(outs(), 16'h0414);
		acc(0, 8'h18, 0, 0);
		check(rdOut, 32'h0000_0000);
		$display("test reset done");
	endtask
	task automatic t_cfg();
		int b[9] = '{15, 14, 13, 12, 10, 7, 4, 2, 0};
		foreach (b[i])
		begin
			acc(1, 8'h40, 32'h1 << b[i], 4'h3);
			check(outs(), 16'h1 << b[i]);
			acc(0, 8'h40, 0, 0);
			check(rdOut, 32'h1 << b[i]);
		end
		// Upper byte strobe off, so bit 15 must stay clear
		acc(1, 8'h40, 32'h0000_8000, 4'h1);
		check(outs(), 16'h0000);
		check(respOut, RESP_OKAY);
		$display("test config done");
	endtask
	task automatic t_status();
		lpNp <= 1'b1;
		lpAn <= 1'b1;
		pageRx <= 1'b1;
		parallel_detect_fault <= 1'b1;
		@(posedge mclk);
		pageRx <= 1'b0;
		parallel_detect_fault <= 1'b0;
		repeat (4) @(posedge mclk);
		acc(0, 8'h18, 0, 0);
		check(rdOut, 32'h0000_001B);
		check(respOut, RESP_OKAY);
		acc(0, 8'h18, 0, 0);
		check(rdOut, 32'h0000_0009);
		acc(1, 8'h18, 32'h0000_FFFF, 4'hF);
		check(respOut, RESP_OKAY);
		acc(0, 8'h18, 0, 0);
		check(rdOut, 32'h0000_0009);
		// A fault still present at the clearing read keeps the bit set
		parallel_detect_fault <= 1'b1;
		@(posedge mclk);
		acc(0, 8'h18, 0, 0);
		check(rdOut, 32'h0000_0019);
		acc(0, 8'h18, 0, 0);
		check(rdOut, 32'h0000_0019);
		parallel_detect_fault <= 1'b0;
		repeat (2) @(posedge mclk);
		acc(0, 8'h18, 0, 0);
		check(rdOut, 32'h0000_0019);
		acc(0, 8'h18, 0, 0);
		check(rdOut, 32'h0000_0009);
		$display("test status done");
	endtask
	task automatic t_phy_state_machine_reset();
		smLen = 0;
		acc(1, 8'h40, 32'h0000_041C, 4'h3);
		repeat (20) @(posedge mclk);
		check(smLen, 16);
		acc(0, 8'h40, 0, 0);
		check(rdOut, 32'h0000_0414);
		$display("test state reset done");
	endtask
	task automatic t_sleep();
		acc(1, 8'h40, 32'h0000_0417, 4'h3);
		check(slp, 1'b1);
		smLen = 0;
		acc(1, 8'h40, 32'h0000_0415, 4'h3);
		repeat (20) @(posedge mclk);
		check(smLen, 16);
		check(outs(), 16'h0415);
		$display("test sleep done");
	endtask
	task automatic t_unmapped();
		acc(0, 8'h20, 0, 0);
		check(respOut, RESP_SLVERR);
		check(rdOut, 32'h0000_0000);
		acc(1, 8'h20, 32'h0000_FFFF, 4'hF);
		check(respOut, RESP_SLVERR);
		check(outs(), 16'h0415);
		$display("test unmapped done");
	endtask
	// Chip reset while asleep must bring back the reset setup without a wake pulse
	task automatic t_midreset();
		acc(1, 8'h40, 32'h0000_8003, 4'h3);
		check(respOut, RESP_OKAY);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		check(outs(), 16'h0414);
		acc(0, 8'h40, 0, 0);
		check(rdOut, 32'h0000_0414);
		$display("test mid reset done");
	endtask
	task automatic test_done();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_cfg();
		t_status();
		t_phy_state_machine_reset();
		t_sleep();
		t_unmapped();
		t_midreset();
		test_done();
	end
endmodule // phy_autoneg_expansion_and_config_regs_bench
`default_nettype wire
